// File: hdl/speed_loop_mode_switch.sv
// Mode switch selector, feedforward path and force reference filter chain
`timescale 1ns/1ps
`default_nettype none
`include "speed_loop_params.svh"
// Function
// RULE1: Add feedforward term scaled by gain in position
// RULE2: Smooth feedforward term with its time constant
// RULE3: Host keeps feedforward gain below eighty percent
// RULE4: Selection digit picks force, speed, accel, error, none
// RULE5: Mode switching enabled only for codes zero-three
// RULE6: I-P speed loop disables mode switching
// RULE7: Force above threshold forces proportional control
// RULE8: Speed reference above threshold forces proportional control
// RULE9: Acceleration above threshold forces proportional control
// RULE10: Position error above threshold forces proportional
// RULE11: Error selection works only in position control
// RULE12: Selection changes take effect at once
// RULE13: Force path: lag stage then series notches
// RULE14: Each notch stage individually enabled or bypassed
// RULE15: Lag time constant set in 0.01 ms units
// RULE16: Notch enable bits: bit0 first, bit1 second
// RULE17: Below threshold returns to proportional-integral control

// ----------------------------------------------------------------------
// First-order lag stage, alpha = 1/(tc+1) per filter tick
// ----------------------------------------------------------------------
module lag_stage #(
    parameter int W    = 24,
    parameter int TC_W = 16
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                tick,
    input  wire logic [TC_W-1:0]     tc,
    input  wire logic signed [W-1:0] x,
    output logic signed [W-1:0]      y
);
    if (W < TC_W + 2) begin : g_w_check
        $error("lag_stage: W too narrow for time constant");
    end

    logic signed [W-1:0] y_q;
    wire  signed [W:0]   diff_w = {x[W-1], x} - {y_q[W-1], y_q};
    wire  signed [W:0]   den_w  = $signed({{(W-TC_W){1'b0}}, tc} + {{W{1'b0}}, 1'b1});
    wire  signed [W:0]   step_w = diff_w / den_w;
    wire  signed [W:0]   sum_w  = {y_q[W-1], y_q} + step_w;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) y_q <= '0;
        else if (tick) y_q <= sum_w[W-1:0];
    end
    assign y = y_q;
endmodule : lag_stage

// ----------------------------------------------------------------------
// Notch stage: comb notch (x + x[n-D]) / 2, bypassed when disabled
// ----------------------------------------------------------------------
module notch_stage #(
    parameter int W = 24,
    parameter int D = 4
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                tick,
    input  wire logic                enable,
    input  wire logic signed [W-1:0] x,
    output logic signed [W-1:0]      y
);
    if (D < 1) begin : g_d_check
        $error("notch_stage: delay must be at least one");
    end

    logic signed [W-1:0] hist_q [D];
    logic signed [W-1:0] y_q;
    wire  signed [W:0]   sum_w   = {x[W-1], x} + {hist_q[D-1][W-1], hist_q[D-1]};
    wire  signed [W:0]   half_w  = sum_w >>> 1;
    wire  signed [W-1:0] shaped_w = enable ? half_w[W-1:0] : x; // RULE14

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < D; i++) hist_q[i] <= '0;
            y_q <= '0;
        end else if (tick) begin
            hist_q[0] <= x;
            for (int i = 1; i < D; i++) hist_q[i] <= hist_q[i-1];
            y_q <= shaped_w;
        end
    end
    assign y = y_q;
endmodule : notch_stage

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module speed_loop_mode_switch #(
    parameter int W        = speed_loop_pkg::DET_W,
    parameter int NOTCH1_D = 4,
    parameter int NOTCH2_D = 2
) (
    // Clock and reset
    input  wire logic                         i_core_clk,
    input  wire logic                         i_rst_b,
    // Settings
    input  wire logic [6:0]                   i_feedforward_gain,
    input  wire logic [12:0]                  i_feedforward_filter_tc,
    input  wire logic [3:0]                   i_mode_switch_select,
    input  wire speed_loop_pkg::threshold_t   i_thresholds,
    input  wire logic [15:0]                  i_force_filter_tc,
    input  wire logic [1:0]                   i_notch_enable_select,
    input  wire logic                         i_ip_control,
    input  wire logic                         i_position_mode,
    // Loop quantities
    input  wire speed_loop_pkg::detect_t      i_detect,
    input  wire logic signed [W-1:0]          i_position_ref_delta,
    // Results
    output logic                              o_prop_integral_switching,
    output logic signed [W-1:0]               o_feedforward,
    output logic signed [W-1:0]               o_force_filtered,
    output logic                              o_filter_tick
);
    if (W != speed_loop_pkg::DET_W) begin : g_w_check
        $error("W must match the detection width");
    end

    // ------------------------------------------------------------------
    // Filter tick, one per 0.01 ms so time constants count in ticks
    // ------------------------------------------------------------------
    localparam logic [11:0] TICK_LAST = 12'(`FILTER_TICK_CYCLES - 1);
    logic [11:0] tick_cnt_q;
    wire         tick_w = (tick_cnt_q == TICK_LAST);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) tick_cnt_q <= '0;
        else tick_cnt_q <= tick_w ? 12'h000 : tick_cnt_q + 12'h001;
    end

    // ------------------------------------------------------------------
    // Feedforward path
    // ------------------------------------------------------------------
    // Out-of-range settings are clamped rather than wrapped
    wire [6:0]  ff_gain_w = (i_feedforward_gain > `FF_GAIN_MAX) ? `FF_GAIN_MAX : i_feedforward_gain;
    wire [12:0] ff_tc_w   = (i_feedforward_filter_tc > `FF_FILTER_TC_MAX) ? `FF_FILTER_TC_MAX
                                                                          : i_feedforward_filter_tc;
    wire signed [W+8:0] ff_prod_w = i_position_ref_delta * $signed({3'b000, ff_gain_w}); // RULE1
    wire signed [W+8:0] ff_scal_w = ff_prod_w / $signed({2'b00, `FF_GAIN_DIVISOR});
    wire signed [W-1:0] ff_lag_w;

    lag_stage #(.W(W), .TC_W(13)) u_ff_lag ( // RULE2
        .clk   (i_core_clk),
        .rst_b (i_rst_b),
        .tick  (tick_w),
        .tc    (ff_tc_w),
        .x     (ff_scal_w[W-1:0]),
        .y     (ff_lag_w)
    );

    // ------------------------------------------------------------------
    // Force reference chain: lag, notch 1, notch 2
    // ------------------------------------------------------------------
    wire signed [W-1:0] lag_out_w;
    wire signed [W-1:0] notch1_out_w;
    wire signed [W-1:0] notch2_out_w;

    lag_stage #(.W(W), .TC_W(16)) u_force_lag ( // RULE13 RULE15
        .clk   (i_core_clk),
        .rst_b (i_rst_b),
        .tick  (tick_w),
        .tc    (i_force_filter_tc),
        .x     (i_detect.force_ref),
        .y     (lag_out_w)
    );

    notch_stage #(.W(W), .D(NOTCH1_D)) u_notch1 (
        .clk    (i_core_clk),
        .rst_b  (i_rst_b),
        .tick   (tick_w),
        .enable (i_notch_enable_select[`NOTCH1_EN_BIT]), // RULE16
        .x      (lag_out_w),
        .y      (notch1_out_w)
    );

    notch_stage #(.W(W), .D(NOTCH2_D)) u_notch2 (
        .clk    (i_core_clk),
        .rst_b  (i_rst_b),
        .tick   (tick_w),
        .enable (i_notch_enable_select[`NOTCH2_EN_BIT]), // RULE16
        .x      (notch1_out_w),
        .y      (notch2_out_w)
    );

    // ------------------------------------------------------------------
    // Mode switch detection, decoded combinationally so a new
    // selection acts on the very next edge
    // ------------------------------------------------------------------
    function automatic logic [W-1:0] mag(input logic signed [W-1:0] v);
        mag = v[W-1] ? -v : v;
    endfunction

    wire [W-1:0] thr_force_w = W'(i_thresholds.force_level_threshold);
    wire [W-1:0] thr_speed_w = W'(i_thresholds.speed_level_threshold);
    wire [W-1:0] thr_accel_w = W'(i_thresholds.accel_level_threshold);
    wire [W-1:0] thr_error_w = W'(i_thresholds.error_level_threshold);

    wire over_force_w = mag(i_detect.force_ref) > thr_force_w; // RULE7
    wire over_speed_w = mag(i_detect.speed_ref) > thr_speed_w; // RULE8
    wire over_accel_w = mag(i_detect.accel) > thr_accel_w;     // RULE9
    wire over_error_w = mag(i_detect.pos_err) > thr_error_w && i_position_mode; // RULE10 RULE11

    wire sel_valid_w = (i_mode_switch_select <= `SEL_ERROR_LEVEL) && !i_ip_control; // RULE5 RULE6
    wire hit_w = (i_mode_switch_select == `SEL_FORCE_LEVEL) ? over_force_w : // RULE4 RULE12
                 (i_mode_switch_select == `SEL_SPEED_LEVEL) ? over_speed_w :
                 (i_mode_switch_select == `SEL_ACCEL_LEVEL) ? over_accel_w :
                 (i_mode_switch_select == `SEL_ERROR_LEVEL) ? over_error_w : 1'b0;
    wire prop_d = sel_valid_w && hit_w; // RULE17

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    logic               prop_q;
    logic signed [W-1:0] ff_q;
    logic signed [W-1:0] force_q;
    logic               tick_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prop_q  <= 1'b0;
            ff_q    <= '0;
            force_q <= '0;
            tick_q  <= 1'b0;
        end else begin
            prop_q  <= prop_d;
            ff_q    <= i_position_mode ? ff_lag_w : '0; // RULE1
            force_q <= notch2_out_w;
            tick_q  <= tick_w;
        end
    end

    assign o_prop_integral_switching = prop_q;
    assign o_feedforward             = ff_q;
    assign o_force_filtered          = force_q;
    assign o_filter_tick             = tick_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_force_sel_over;
        (i_mode_switch_select == `SEL_FORCE_LEVEL) && !i_ip_control && (mag(i_detect.force_ref) > thr_force_w);
    endsequence

    property p_sel_none;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mode_switch_select == `SEL_NO_SWITCH) |=> !o_prop_integral_switching;
    endproperty
    a_sel_none: assert property (p_sel_none) else $error("switched with selection four"); // RULE4

    property p_sel_invalid;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mode_switch_select > `SEL_ERROR_LEVEL) |=> !o_prop_integral_switching;
    endproperty
    a_sel_invalid: assert property (p_sel_invalid) else $error("switched with disabled code"); // RULE5

    property p_ip_block;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_ip_control |=> !o_prop_integral_switching;
    endproperty
    a_ip_block: assert property (p_ip_block) else $error("switched under I-P control"); // RULE6

    property p_force;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        s_force_sel_over |=> o_prop_integral_switching;
    endproperty
    a_force: assert property (p_force) else $error("force level did not switch"); // RULE7

    property p_speed;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mode_switch_select == `SEL_SPEED_LEVEL) && !i_ip_control && (mag(i_detect.speed_ref) > thr_speed_w)
        |=> o_prop_integral_switching;
    endproperty
    a_speed: assert property (p_speed) else $error("speed level did not switch"); // RULE8

    property p_accel;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mode_switch_select == `SEL_ACCEL_LEVEL) && !i_ip_control && (mag(i_detect.accel) > thr_accel_w)
        |=> o_prop_integral_switching;
    endproperty
    a_accel: assert property (p_accel) else $error("accel level did not switch"); // RULE9

    property p_error;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mode_switch_select == `SEL_ERROR_LEVEL) && !i_ip_control && i_position_mode
        && (mag(i_detect.pos_err) > thr_error_w) |=> o_prop_integral_switching;
    endproperty
    a_error: assert property (p_error) else $error("error level did not switch"); // RULE10

    property p_error_off;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mode_switch_select == `SEL_ERROR_LEVEL) && !i_position_mode |=> !o_prop_integral_switching;
    endproperty
    a_error_off: assert property (p_error_off) else $error("error switch outside position mode"); // RULE11

    property p_release;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_mode_switch_select == `SEL_FORCE_LEVEL) && !(mag(i_detect.force_ref) > thr_force_w)
        |=> !o_prop_integral_switching;
    endproperty
    a_release: assert property (p_release) else $error("no return to PI control"); // RULE17

    property p_ff_gate;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !i_position_mode |=> (o_feedforward == '0);
    endproperty
    a_ff_gate: assert property (p_ff_gate) else $error("feedforward outside position mode"); // RULE1

    property p_tick_period;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        tick_w |=> !tick_w [*8];
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("filter tick too frequent"); // RULE15

endmodule : speed_loop_mode_switch
`default_nettype wire

// File: shared/speed_loop_params.svh
// Constants for the speed loop mode switch and reference shaping block
`ifndef SPEED_LOOP_PARAMS_SVH
`define SPEED_LOOP_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CORE_CLK_PERIOD_NS   10'd5
`define FILTER_TICK_NS       14'd10000
`define FILTER_TICK_CYCLES   (`FILTER_TICK_NS / `CORE_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Setting limits
// ----------------------------------------------------------------------
`define FF_GAIN_MAX          7'd100
`define FF_GAIN_DIVISOR      8'd100
`define FF_FILTER_TC_MAX     13'd6400

// ----------------------------------------------------------------------
// Mode switch selection codes (lowest digit)
// ----------------------------------------------------------------------
`define SEL_FORCE_LEVEL      4'h0
`define SEL_SPEED_LEVEL      4'h1
`define SEL_ACCEL_LEVEL      4'h2
`define SEL_ERROR_LEVEL      4'h3
`define SEL_NO_SWITCH        4'h4

// ----------------------------------------------------------------------
// Notch enable field positions
// ----------------------------------------------------------------------
`define NOTCH1_EN_BIT        0
`define NOTCH2_EN_BIT        1

`endif

// File: shared/speed_loop_pkg.sv
// Types for the speed loop mode switch and reference shaping block
`default_nettype none
package speed_loop_pkg;

    localparam int DET_W = 24;

    // Detection quantities sampled from the servo loop
    typedef struct packed {
        logic signed [DET_W-1:0] force_ref;
        logic signed [DET_W-1:0] speed_ref;
        logic signed [DET_W-1:0] accel;
        logic signed [DET_W-1:0] pos_err;
    } detect_t;

    // Detection thresholds, unsigned
    typedef struct packed {
        logic [15:0] force_level_threshold;
        logic [15:0] speed_level_threshold;
        logic [15:0] accel_level_threshold;
        logic [15:0] error_level_threshold;
    } threshold_t;

endpackage : speed_loop_pkg
`default_nettype wire

// File: tb/host_model.sv
// Host-side model that supplies loop quantities, references and the feedforward gain
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Requested values
    input  wire speed_loop_pkg::detect_t i_req_detect,
    input  wire logic signed [23:0]      i_req_delta,
    input  wire logic [6:0]              i_req_gain,
    // Towards the drive
    output var speed_loop_pkg::detect_t  o_detect,
    output logic signed [23:0]           o_delta,
    output logic [6:0]                   o_gain
);
    // Gain capped below 80 percent, since higher settings risk machine vibration
    assign o_gain   = (i_req_gain > 7'h4F) ? 7'h4F : i_req_gain;
    assign o_detect = i_req_detect;
    assign o_delta  = i_req_delta;
endmodule : host_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the mode switch and reference shaping block
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                       i_core_clk = 1'b0;
    logic                       i_rst_b    = 1'b0;
    logic [6:0]                 req_gain   = 7'h00;
    logic [12:0]                ff_tc      = 13'h0000;
    logic [3:0]                 sel        = 4'h0;
    speed_loop_pkg::threshold_t thr        = '0;
    logic [15:0]                force_tc   = 16'h0000;
    logic [1:0]                 notch_en   = 2'h0;
    logic                       ip         = 1'b0;
    logic                       pos_mode   = 1'b0;
    speed_loop_pkg::detect_t    req_det    = '0;
    logic signed [23:0]         req_delta  = 24'h000000;
    speed_loop_pkg::detect_t    det;
    logic signed [23:0]         delta;
    logic [6:0]                 gain;
    logic                       prop;
    logic signed [23:0]         ff;
    logic signed [23:0]         force_out;
    logic                       tick;
    int                         err_count  = 0;
    int                         n_compared = 0;

    always #2.5 i_core_clk = ~i_core_clk;

    host_model i_host_model (.i_req_detect(req_det), .i_req_delta(req_delta), .i_req_gain(req_gain),
                             .o_detect(det), .o_delta(delta), .o_gain(gain));

    speed_loop_mode_switch i_speed_loop_mode_switch (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_feedforward_gain(gain),
        .i_feedforward_filter_tc(ff_tc), .i_mode_switch_select(sel), .i_thresholds(thr),
        .i_force_filter_tc(force_tc), .i_notch_enable_select(notch_en), .i_ip_control(ip),
        .i_position_mode(pos_mode), .i_detect(det), .i_position_ref_delta(delta),
        .o_prop_integral_switching(prop), .o_feedforward(ff), .o_force_filtered(force_out),
        .o_filter_tick(tick));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // Magnitude strictly above threshold; codes above 3, I-P, or error level outside position give PI
    function automatic logic exp_prop(input logic [3:0] s, input speed_loop_pkg::threshold_t t,
                                      input speed_loop_pkg::detect_t d, input logic ipv, input logic pmv);
        logic [23:0] v;
        if (s > 4'h3 || ipv || (s == 4'h3 && !pmv)) return 1'b0;
        v = d[(3 - s) * 24 +: 24];
        if (v[23]) v = -v;
        return v > {8'h00, t[(3 - s) * 16 +: 16]};
    endfunction : exp_prop

    // Bounded wait for the next filter update pulse, returning once the outputs carry that update
    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (tick !== 1'b1 && n < 2100);
        if (n >= 2100) check("filter_tick", 24'h000000, 24'h000001);
        // Registered outputs take the new sample one edge after the pulse rises
        @(negedge i_core_clk);
    endtask : wait_tick

    // A half-height sample appears while a notch mixes old and new input, or while a lag with tc of one rises
    task automatic watch_half(input int n, output logic seen);
        seen = 1'b0;
        repeat (n) begin
            wait_tick();
            if (force_out === 24'sh0001F4) seen = 1'b1;
        end
    endtask : watch_half

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    task automatic test_mode_switch();
        logic [3:0]                 s;
        speed_loop_pkg::threshold_t t;
        speed_loop_pkg::detect_t    d;
        logic [23:0]                m;
        logic                       ipv;
        logic                       pmv;
        for (int i = 0; i < 400; i++) begin
            s   = ($urandom_range(0, 9) == 0) ? 4'hF : 4'($urandom_range(0, 4));
            ipv = ($urandom_range(0, 7) == 0);
            pmv = 1'($urandom_range(0, 1));
            for (int f = 0; f < 4; f++) begin
                t[f * 16 +: 16] = 16'($urandom_range(0, 30000));
                m = ($urandom_range(0, 3) == 0) ? 24'(t[f * 16 +: 16]) : 24'($urandom_range(0, 40000));
                d[f * 24 +: 24] = $urandom_range(0, 1) ? -m : m;
            end
            // Hand-set corners: just above and exactly at the threshold
            if (i < 2) begin
                s   = 4'h0;
                ipv = 1'b0;
                t.force_level_threshold = 16'h00C8;
                d.force_ref = (i == 0) ? -24'sh0000C9 : 24'sh0000C8;
            end
            @(posedge i_core_clk);
            sel      <= s;
            thr      <= t;
            req_det  <= d;
            ip       <= ipv;
            pos_mode <= pmv;
            @(posedge i_core_clk);
            @(negedge i_core_clk);
            check("prop_integral", {23'h0, prop}, {23'h0, exp_prop(s, t, d, ipv, pmv)});
        end
        $display("Test mode switch done");
    endtask : test_mode_switch

    task automatic test_filters();
        logic seen;
        int   cyc;
        @(posedge i_core_clk);
        pos_mode  <= 1'b1;
        req_gain  <= 7'h32;
        req_delta <= 24'sh0003E8;
        for (int j = 0; j < 3; j++) begin
            @(posedge i_core_clk);
            notch_en <= 2'(j);
            req_det.force_ref <= 24'sh0003E8;
            repeat (5) wait_tick();
            if (j == 0) begin
                check("force_filtered", force_out, 24'h0003E8);
                check("feedforward", ff, 24'h0001F4);
            end
            @(posedge i_core_clk);
            req_det.force_ref <= 24'sh000000;
            watch_half(5, seen);
            check("notch_half_step", {23'h0, seen}, {23'h0, (j != 0)});
        end
        // Feedforward smoothing: tc of one halves the gap each update
        @(posedge i_core_clk);
        ff_tc     <= 13'h0001;
        req_delta <= 24'sh000000;
        wait_tick();
        check("feedforward_smoothed", ff, 24'h0000FA);
        // Lag with tc of one shows a half step on its way up
        @(posedge i_core_clk);
        notch_en <= 2'h0;
        force_tc <= 16'h0001;
        req_det.force_ref <= 24'sh0003E8;
        watch_half(5, seen);
        check("lag_half_step", {23'h0, seen}, 24'h000001);
        @(posedge i_core_clk);
        pos_mode <= 1'b0;
        repeat (2) wait_tick();
        check("feedforward_off", ff, 24'h000000);
        // One filter update per 0.01 ms, i.e. every 2000 clocks at 5 ns
        cyc = 0;
        do begin
            @(negedge i_core_clk);
            cyc++;
        end while (tick !== 1'b1 && cyc < 2100);
        check("tick_period", 24'(cyc), 24'h0007CF);
        $display("Test filters done");
    endtask : test_filters

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(84));
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        test_mode_switch();
        test_filters();
        give_verdict();
    end

    initial begin
        repeat (92000) @(posedge i_core_clk);
        err_count++;
        $display("Watchdog expired before the tests ended");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
